// ===== include/power_path_consts.svh
/*
 * Constants of the power-path control register: offset, reset value,
 * field positions, write mask and current-limit figures in milliamps.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef POWER_PATH_CONSTS_SVH
`define POWER_PATH_CONSTS_SVH

// Register location and reset
`define PPC_OFFSET        8'h01
`define PPC_RESET         8'h3d

// Field positions
`define PPC_AC_SINK_BIT   7
`define PPC_USB_SINK_BIT  6
`define PPC_AC_PATH_ENABLE_BIT     5
`define PPC_USB_EN_BIT    4
`define PPC_AC_ILIM_MSB   3
`define PPC_AC_ILIM_LSB   2
`define PPC_USB_ILIM_MSB  1
`define PPC_USB_ILIM_LSB  0

// Bits a write may change; limit LSBs stay as stored
`define PPC_WR_MASK       8'hfa

// Read value at any other offset
`define PPC_UNMAPPED      8'h00

// Limits in mA: 100, 500, 1300, 2500 (AC top), 1800 (USB top)
`define ILIM_MA_100       12'h064
`define ILIM_MA_500       12'h1f4
`define ILIM_MA_1300      12'h514
`define ILIM_MA_AC_TOP    12'h9c4
`define ILIM_MA_USB_TOP   12'h708

`endif

// ===== include/power_path_pkg.sv
/*
 * Types of the power-path control register.
 * Assumes nothing of its surroundings.
 */
package power_path_pkg;

	typedef logic [1:0]  ilim_code_t;
	typedef logic [11:0] milliamp_t;

	typedef struct packed {
		logic       ac_sink_ctrl;
		logic       usb_sink_ctrl;
		logic       ac_path_enable;
		logic       usb_path_enable;
		ilim_code_t ac_current_limit;
		ilim_code_t usb_current_limit;
	} power_path_reg_t;

endpackage

// ===== include/power_path_if.sv
/*
 * Carrier between the register and the sink decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface power_path_if;
	logic ac_sink_ctrl;
	logic usb_sink_ctrl;
	logic usb_valid;
	logic ac_valid;
	logic ac_below_det;
	logic usb_below_det;
	logic ac_sink_en;
	logic usb_sink_en;

	modport regs (
		output ac_sink_ctrl, usb_sink_ctrl,
		output usb_valid, ac_valid, ac_below_det, usb_below_det,
		input  ac_sink_en, usb_sink_en
	);
	modport decoder (
		input  ac_sink_ctrl, usb_sink_ctrl,
		input  usb_valid, ac_valid, ac_below_det, usb_below_det,
		output ac_sink_en, usb_sink_en
	);
endinterface

`default_nettype wire

// ===== rtl/sink_enable_decode.sv
/*
 * Combinational decode of the two current-sink enables from the sink
 * control bits and the supply conditions.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none

module sink_enable_decode (
	// Control bits in, enables out
	power_path_if.decoder pp
);

	logic force_off;

	always_comb begin
		force_off = pp.ac_sink_ctrl & pp.usb_sink_ctrl;
		// Mixed patterns fall through to per-bit decode, not guarded
		pp.ac_sink_en = ~force_off & ~pp.ac_sink_ctrl & pp.usb_valid
			& pp.ac_below_det;
		pp.usb_sink_en = ~force_off & ~pp.usb_sink_ctrl & pp.ac_valid
			& pp.usb_below_det;
	end

endmodule

`default_nettype wire

// ===== rtl/power_path_control_register.sv
/*
 * Power-path control register: storage, readback, and registered
 * control outputs to the power-path circuitry.
 * Assumes a register-bank port driven by the serial interface logic,
 * synchronous supply-detect inputs, and one clock.
 */
// What this block does
// - Register sits at offset 0x01 and resets to 0x3D.
// - AC sink bit 0: AC sink on while USB valid and AC below threshold.
// - USB sink bit 0: USB sink on while AC valid and USB below threshold.
// - Both sink bits 1: both sinks forced off regardless of supplies.
// - AC path enable bit: 0 turns AC input off, 1 on.
// - USB path enable bit: 1 on, 0 off meaning USB suspend.
// - AC limit code selects 100, 500, 1300, 2500 mA; resets to 11b.
// - USB limit code selects 100, 500, 1300, 1800 mA; resets to 01b.
// - Low bit of each limit field ignores writes, keeps stored value.
`timescale 1ns/1ps
`default_nettype none
`include "power_path_consts.svh"

module power_path_control_register
	import power_path_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Register-bank port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd_en,
	output logic      [7:0] reg_rdata,
	// Supply conditions
	input  wire logic       usb_valid,
	input  wire logic       ac_valid,
	input  wire logic       ac_below_det,
	input  wire logic       usb_below_det,
	// Controls to the power path
	output logic            ac_sink_on,
	output logic            usb_sink_on,
	output logic            ac_path_on,
	output logic            usb_path_on,
	output logic            usb_suspend,
	output ilim_code_t      ac_current_limit,
	output ilim_code_t      usb_current_limit,
	output milliamp_t       ac_limit_ma,
	output milliamp_t       usb_limit_ma
);

	////////////////////////////////////////////////////////////////////////

	function automatic milliamp_t ilim_ma(input ilim_code_t code,
		input milliamp_t top);
		unique case (code)
			2'h0: ilim_ma = `ILIM_MA_100;
			2'h1: ilim_ma = `ILIM_MA_500;
			2'h2: ilim_ma = `ILIM_MA_1300;
			2'h3: ilim_ma = top;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register storage and readback

	power_path_reg_t reg_q;
	power_path_reg_t reg_d;
	logic [7:0]      rdata_q;
	logic [7:0]      rdata_d;
	logic            hit;

	always_comb begin
		hit = (reg_addr == `PPC_OFFSET);
		reg_d = reg_q;
		if (reg_wr_en && hit) begin
			// Limit LSBs are fixed; a write cannot move them
			reg_d = (reg_wdata & `PPC_WR_MASK)
				| (reg_q & ~`PPC_WR_MASK);
		end
		rdata_d = rdata_q;
		if (reg_rd_en) begin
			rdata_d = hit ? reg_q : `PPC_UNMAPPED;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_q   <= `PPC_RESET;
			rdata_q <= 8'h00;
		end else begin
			reg_q   <= reg_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Sink decode

	power_path_if pp ();

	always_comb begin
		// Decode from the next value so a write acts in one cycle
		pp.ac_sink_ctrl  = reg_d.ac_sink_ctrl;
		pp.usb_sink_ctrl = reg_d.usb_sink_ctrl;
		pp.usb_valid     = usb_valid;
		pp.ac_valid      = ac_valid;
		pp.ac_below_det  = ac_below_det;
		pp.usb_below_det = usb_below_det;
	end

	sink_enable_decode sink_enable_decode_i (
		.pp (pp.decoder)
	);

	////////////////////////////////////////////////////////////////////////
	// Registered control outputs

	logic      ac_sink_q,  ac_sink_d;
	logic      usb_sink_q, usb_sink_d;
	milliamp_t ac_ma_q,    ac_ma_d;
	milliamp_t usb_ma_q,   usb_ma_d;

	always_comb begin
		ac_sink_d  = pp.ac_sink_en;
		usb_sink_d = pp.usb_sink_en;
		ac_ma_d    = ilim_ma(reg_d.ac_current_limit,
			`ILIM_MA_AC_TOP);
		usb_ma_d   = ilim_ma(reg_d.usb_current_limit,
			`ILIM_MA_USB_TOP);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ac_sink_q  <= 1'b0;
			usb_sink_q <= 1'b0;
			ac_ma_q    <= `ILIM_MA_AC_TOP;
			usb_ma_q   <= `ILIM_MA_500;
		end else begin
			ac_sink_q  <= ac_sink_d;
			usb_sink_q <= usb_sink_d;
			ac_ma_q    <= ac_ma_d;
			usb_ma_q   <= usb_ma_d;
		end
	end

	// Path and limit-code outputs come straight from the register flops; sink and mA outputs from their own flops
	assign ac_sink_on        = ac_sink_q;
	assign usb_sink_on       = usb_sink_q;
	assign ac_path_on        = reg_q.ac_path_enable;
	assign usb_path_on       = reg_q.usb_path_enable;
	assign usb_suspend       = ~reg_q.usb_path_enable;
	assign ac_current_limit  = reg_q.ac_current_limit;
	assign usb_current_limit = reg_q.usb_current_limit;
	assign ac_limit_ma       = ac_ma_q;
	assign usb_limit_ma      = usb_ma_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Marks the first cycle whose $past is free of reset
	logic rst_done_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_done_q <= 1'b0;
		end else begin
			rst_done_q <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_RESET_STATE: assert property (
		$rose(rst_done_q) && !$past(reg_wr_en) |-> reg_q == `PPC_RESET)
		else $error("register not at reset value after reset");

	AST_SINK_CTRL_RESET: assert property (
		$rose(rst_done_q) && !$past(reg_wr_en)
		|-> !reg_q.ac_sink_ctrl && !reg_q.usb_sink_ctrl)
		else $error("sink control bits not zero after reset");

	AST_READBACK: assert property (
		reg_rd_en |=> reg_rdata == ($past(reg_addr) == `PPC_OFFSET
			? $past(reg_q) : `PPC_UNMAPPED))
		else $error("readback mismatch");

	AST_OTHER_OFFSET: assert property (
		reg_wr_en && reg_addr != `PPC_OFFSET |=> $stable(reg_q))
		else $error("write to other offset changed register");

	AST_AC_SINK: assert property (
		rst_done_q |-> ac_sink_on == (!reg_q.ac_sink_ctrl
			&& $past(usb_valid) && $past(ac_below_det)))
		else $error("AC sink level wrong");

	AST_USB_SINK: assert property (
		rst_done_q |-> usb_sink_on == (!reg_q.usb_sink_ctrl
			&& $past(ac_valid) && $past(usb_below_det)))
		else $error("USB sink level wrong");

	AST_FORCE_OFF: assert property (
		reg_q.ac_sink_ctrl && reg_q.usb_sink_ctrl
		|-> !ac_sink_on && !usb_sink_on)
		else $error("sinks not forced off");

	AST_AC_PATH: assert property (
		reg_wr_en && reg_addr == `PPC_OFFSET
		|=> ac_path_on == $past(reg_wdata[`PPC_AC_PATH_ENABLE_BIT]))
		else $error("AC path enable not applied");

	AST_USB_SUSPEND: assert property (
		reg_wr_en && reg_addr == `PPC_OFFSET
		|=> usb_path_on == $past(reg_wdata[`PPC_USB_EN_BIT])
			&& usb_suspend == !usb_path_on)
		else $error("USB path or suspend wrong");

	AST_AC_LIMIT_MA: assert property (
		rst_done_q |-> ac_limit_ma == (ac_current_limit == 2'h3
			? `ILIM_MA_AC_TOP : ac_current_limit == 2'h2
			? `ILIM_MA_1300 : ac_current_limit == 2'h1
			? `ILIM_MA_500 : `ILIM_MA_100))
		else $error("AC limit decode wrong");

	AST_USB_LIMIT_MA: assert property (
		rst_done_q |-> usb_limit_ma == (usb_current_limit == 2'h3
			? `ILIM_MA_USB_TOP : usb_current_limit == 2'h2
			? `ILIM_MA_1300 : usb_current_limit == 2'h1
			? `ILIM_MA_500 : `ILIM_MA_100))
		else $error("USB limit decode wrong");

	AST_LSB_FIXED: assert property (
		reg_wr_en |=> ac_current_limit[0] == $past(ac_current_limit[0])
			&& usb_current_limit[0] == $past(usb_current_limit[0]))
		else $error("limit LSB changed by write");

	AST_WRITE_EFFECT: assert property (
		reg_wr_en && reg_addr == `PPC_OFFSET
		|=> ac_current_limit[1] == $past(reg_wdata[`PPC_AC_ILIM_MSB])
			&& usb_current_limit[1]
			== $past(reg_wdata[`PPC_USB_ILIM_MSB]))
		else $error("limit field not applied after write");

	COV_WRITE: cover property (
		reg_wr_en && reg_addr == `PPC_OFFSET ##2 reg_rd_en);
	COV_FORCE_OFF: cover property (
		reg_q.ac_sink_ctrl && reg_q.usb_sink_ctrl && ac_valid
		&& usb_valid);
	COV_AC_SINK_ON: cover property (ac_sink_on);
	COV_USB_SUSPEND: cover property (usb_suspend);

endmodule

`default_nettype wire

// ===== dv/power_path_host.sv
/*
 * Host model: master of the register-bank port.
 * Assumes one clock shared with the register block.
 */
`timescale 1ns/1ps
`default_nettype none

module power_path_host (
	// Clock
	input  wire logic       sys_clk,
	// Register-bank port
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd_en,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr  = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
	end

	// Callers send the sink bits only as 00b or 11b
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		// Released bus shows junk, so stale data cannot pass
		reg_wdata <= ~data;
		reg_addr  <= ~addr;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		reg_addr  <= addr;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		reg_addr  <= ~addr;
		@(negedge sys_clk);
		data = reg_rdata;
	endtask
endmodule

`default_nettype wire

// ===== dv/power_path_control_register_test.sv
/*
 * Self-checking bench of the power-path control register.
 * Assumes the host model in the dv folder and the design package.
 */
`timescale 1ns/1ps
`default_nettype none

module power_path_control_register_test
	import power_path_pkg::*;
();
	logic       sys_clk;
	logic       arst_n;
	logic [7:0] reg_addr;
	logic       reg_wr_en;
	logic [7:0] reg_wdata;
	logic       reg_rd_en;
	logic [7:0] reg_rdata;
	logic       usb_valid;
	logic       ac_valid;
	logic       ac_below_det;
	logic       usb_below_det;
	logic       ac_sink_on;
	logic       usb_sink_on;
	logic       ac_path_on;
	logic       usb_path_on;
	logic       usb_suspend;
	ilim_code_t ac_current_limit;
	ilim_code_t usb_current_limit;
	milliamp_t  ac_limit_ma;
	milliamp_t  usb_limit_ma;
	int         error_cnt = 0;
	int         checks = 0;
	logic [7:0] v;

	power_path_control_register power_path_control_register_i (
		.sys_clk           (sys_clk),
		.arst_n            (arst_n),
		.reg_addr          (reg_addr),
		.reg_wr_en         (reg_wr_en),
		.reg_wdata         (reg_wdata),
		.reg_rd_en         (reg_rd_en),
		.reg_rdata         (reg_rdata),
		.usb_valid         (usb_valid),
		.ac_valid          (ac_valid),
		.ac_below_det      (ac_below_det),
		.usb_below_det     (usb_below_det),
		.ac_sink_on        (ac_sink_on),
		.usb_sink_on       (usb_sink_on),
		.ac_path_on        (ac_path_on),
		.usb_path_on       (usb_path_on),
		.usb_suspend       (usb_suspend),
		.ac_current_limit  (ac_current_limit),
		.usb_current_limit (usb_current_limit),
		.ac_limit_ma       (ac_limit_ma),
		.usb_limit_ma      (usb_limit_ma)
	);
	power_path_host power_path_host_i (.sys_clk(sys_clk),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [11:0] s,
		input logic [11:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [11:0] ma(input logic [1:0] c, input logic ac);
		case (c)
			2'h0: ma = 12'h064;
			2'h1: ma = 12'h1f4;
			2'h2: ma = 12'h514;
			default: ma = ac ? 12'h9c4 : 12'h708;
		endcase
	endfunction

	// Readback plus every field output against expected image r
	task automatic t_reg(input logic [7:0] r);
		power_path_host_i.rd(8'h01, v);
		chk("reg", v, r);
		chk("ac_path_on", ac_path_on, r[5]);
		chk("usb_path_on", usb_path_on, r[4]);
		chk("usb_suspend", usb_suspend, {11'h000, ~r[4]});
		chk("ac_code", ac_current_limit, r[3:2]);
		chk("usb_code", usb_current_limit, r[1:0]);
		chk("ac_ma", ac_limit_ma, ma(r[3:2], 1'b1));
		chk("usb_ma", usb_limit_ma, ma(r[1:0], 1'b0));
	endtask

	// Limit LSBs stay 1 whatever is written
	task automatic t_write(input logic [7:0] w, input logic [7:0] e);
		power_path_host_i.wr(8'h01, w);
		t_reg(e);
	endtask

	// Every supply combination under sink pattern 00b, then 11b
	task automatic t_sinks;
		logic ea;
		logic eu;
		for (int p = 0; p < 2; p++) begin
			power_path_host_i.wr(8'h01, p ? 8'hff : 8'h3d);
			for (int s = 0; s < 16; s++) begin
				@(posedge sys_clk);
				{usb_valid, ac_valid, ac_below_det,
					usb_below_det} <= s[3:0];
				@(posedge sys_clk);
				@(negedge sys_clk);
				ea = p == 0 && s[3] && s[1];
				eu = p == 0 && s[2] && s[0];
				chk("ac_sink", ac_sink_on, ea);
				chk("usb_sink", usb_sink_on, eu);
			end
		end
	endtask

	task automatic t_unmapped;
		power_path_host_i.wr(8'h02, 8'h00);
		power_path_host_i.rd(8'h01, v);
		chk("reg_kept", v, 8'hff);
		power_path_host_i.rd(8'h02, v);
		chk("unmapped", v, 8'h00);
	endtask

	// Supplies all up: a sink bit reset to 1 would kill a sink
	task automatic t_post_reset;
		t_reg(8'h3d);
		chk("ac_sink_rst", ac_sink_on, 1'b1);
		chk("usb_sink_rst", usb_sink_on, 1'b1);
	endtask

	// Reset after writes must bring back the reset image
	task automatic t_rerst;
		@(posedge sys_clk);
		{usb_valid, ac_valid, ac_below_det, usb_below_det} <= 4'hf;
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_post_reset();
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		#80000;
		error_cnt++;
		end_sim();
	end

	initial begin
		arst_n = 1'b0;
		{usb_valid, ac_valid, ac_below_det, usb_below_det} = 4'hf;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_post_reset();
		t_write(8'h00, 8'h05);
		t_write(8'hff, 8'hff);
		t_sinks();
		t_unmapped();
		t_rerst();
		end_sim();
	end
endmodule

`default_nettype wire
